/* File: rtl/orc_pkg.sv */
/*
 * Shared constants and types for the over-range flag and clock-out block.
 * Assumes a 32-bit classic Wishbone master and a 100 MHz system clock.
 */
package orc_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_THRESH = 8'h04;
    localparam logic [7:0] ADDR_MIN_PULSE = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0c;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
    localparam logic [7:0] ADDR_INT_MASK = 8'h14;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CTRL_OVERRIDE_BIT = 0;
    localparam int CTRL_SEL_LSB = 1;
    localparam int CTRL_DISABLE_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [15:0] THRESH_RESET = 16'h0000;
    localparam logic [15:0] MIN_PULSE_RESET = 16'h0001;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;

    // Clock-select codes
    localparam logic [1:0] SEL_FLAG = 2'h0;
    localparam logic [1:0] SEL_DIV1 = 2'h1;
    localparam logic [1:0] SEL_DIV2 = 2'h2;
    localparam logic [1:0] SEL_DIV4 = 2'h3;

    // Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } orc_wb_req_t;

    // Wishbone answer to the master
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } orc_wb_rsp_t;

endpackage

/* File: rtl/orc_top.sv */
/*
 * Fast over-range flags for channels A to C and the channel C pin mux
 * that can carry the reference clock, undivided or divided, instead.
 * Assumes sample magnitudes and the reference clock level are synchronous
 * to clock, and that straps are stable when rst is released.
 */
// Notes on behaviour
// [RL1] Flag A high when A exceeds threshold
// [RL2] Flag B only on two/four channel parts
// [RL3] Each flag held for minimum pulse count
// [RL4] Flag C only on four channel part
// [RL5] Pin C carries clock when selected, synth on
// [RL6] Code zero or disabled gives flag C
// [RL7] Codes 1/2/3 give ref, ref/2, ref/4
// [RL8] System holds synth on, power-down low, straps
// [RL9] Release only after return and minimum elapsed

// ****************************************
// One channel's flag with minimum pulse
// ****************************************
module orc_chan #(
    parameter int SAMPLE_W = 9,
    parameter int COUNT_W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Detection inputs
    input wire logic present,
    input wire logic [SAMPLE_W-1:0] sample,
    input wire logic [SAMPLE_W-1:0] threshold,
    input wire logic [COUNT_W-1:0] min_count,
    // Flag
    output logic flag
);
    logic flag_ff;
    logic [COUNT_W-1:0] cnt_ff;
    wire over = present && (sample > threshold); // [RL1] [RL2] [RL4]
    wire rise = over && !flag_ff;
    wire hold = flag_ff && (cnt_ff > {{(COUNT_W-1){1'b0}}, 1'b1});
    wire nxt_flag = over || hold; // [RL3] [RL9]
    wire [COUNT_W-1:0] nxt_cnt = rise ? min_count :
                                 (flag_ff && cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;

    // Count reloads only at assertion, so the pulse is timed from its start
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            flag_ff <= 1'b0;
            cnt_ff <= '0;
        end
        else
        begin
            flag_ff <= nxt_flag;
            cnt_ff <= nxt_cnt;
        end
    end

    assign flag = flag_ff;
endmodule

// ****************************************
// Top level with Wishbone registers
// ****************************************
module orc_top #(
    parameter int NUM_CHANNELS = 4,
    parameter int SAMPLE_W = 9
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Wishbone slave
    input wire orc_pkg::orc_wb_req_t wb_req,
    output orc_pkg::orc_wb_rsp_t wb_rsp,
    // Channel sample magnitudes
    input wire logic [SAMPLE_W-1:0] sample_a,
    input wire logic [SAMPLE_W-1:0] sample_b,
    input wire logic [SAMPLE_W-1:0] sample_c,
    // Clocking pins
    input wire logic [1:0] clock_out_select_straps,
    input wire logic synth_enable,
    input wire logic power_down_input,
    input wire logic reference_clock_out,
    // Outputs
    output logic overrange_flag_a,
    output logic overrange_flag_b,
    output logic overrange_c_clock_pin,
    output logic irq
);
    // ****************************************
    // Registers
    // ****************************************
    logic [3:0] ctrl_ff;
    logic [15:0] thresh_ff;
    logic [15:0] min_pulse_ff;
    logic [2:0] int_status_ff;
    logic [2:0] int_mask_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [1:0] strap_ff;
    logic strap_taken_ff;
    logic [2:0] flag_q_ff;
    logic ref_q_ff;
    logic div2_ff;
    logic [1:0] div4_ff;
    logic pin_ff;

    // Bus decode; writes land at the edge where ack is seen
    wire req = wb_req.cyc && wb_req.stb;
    wire wr = req && wb_req.we && ack_ff;
    wire lane0 = wb_req.sel[0];
    wire lane1 = wb_req.sel[1];
    wire hit_ctrl = wb_req.adr == orc_pkg::ADDR_CTRL;
    wire hit_thresh = wb_req.adr == orc_pkg::ADDR_THRESH;
    wire hit_min = wb_req.adr == orc_pkg::ADDR_MIN_PULSE;
    wire hit_state = wb_req.adr == orc_pkg::ADDR_STATE;
    wire hit_ist = wb_req.adr == orc_pkg::ADDR_INT_STATUS;
    wire hit_imask = wb_req.adr == orc_pkg::ADDR_INT_MASK;

    // Write strobes per register and lane, so the flop blocks stay short
    wire wr_ctrl = wr && hit_ctrl && lane0;
    wire wr_thresh_lo = wr && hit_thresh && lane0;
    wire wr_thresh_hi = wr && hit_thresh && lane1;
    wire wr_min_lo = wr && hit_min && lane0;
    wire wr_min_hi = wr && hit_min && lane1;
    wire wr_imask = wr && hit_imask && lane0;
    wire wr_ist = wr && hit_ist && lane0;

    // ****************************************
    // Flag channels
    // ****************************************
    logic [2:0] flags;
    wire [2:0] present = {NUM_CHANNELS >= 4, NUM_CHANNELS >= 2, 1'b1};
    wire [SAMPLE_W-1:0] samples [3];
    assign samples[0] = sample_a;
    assign samples[1] = sample_b;
    assign samples[2] = sample_c;

    // Same detector per channel; absent channels stay low
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_chan
            orc_chan #(.SAMPLE_W(SAMPLE_W), .COUNT_W(16)) u_chan (
                .clock(clock),
                .rst(rst),
                .present(present[gi]),
                .sample(samples[gi]),
                .threshold(thresh_ff[SAMPLE_W-1:0]),
                .min_count(min_pulse_ff),
                .flag(flags[gi])
            );
        end
    endgenerate

    // ****************************************
    // Clock-select and pin mux
    // ****************************************
    wire [1:0] ctrl_sel = ctrl_ff[orc_pkg::CTRL_SEL_LSB +: 2];
    wire [1:0] code = ctrl_ff[orc_pkg::CTRL_OVERRIDE_BIT] ? ctrl_sel : strap_ff;
    // Clock needs synth on, power-down low and no software disable
    wire clk_on = (code != orc_pkg::SEL_FLAG) && synth_enable && !power_down_input &&
                  !ctrl_ff[orc_pkg::CTRL_DISABLE_BIT]; // [RL5] [RL6] [RL8]
    wire ref_rise = reference_clock_out && !ref_q_ff;
    wire clk_level = (code == orc_pkg::SEL_DIV1) ? ref_q_ff :
                     (code == orc_pkg::SEL_DIV2) ? div2_ff : div4_ff[1]; // [RL7]
    wire nxt_pin = clk_on ? clk_level : flags[2]; // [RL5] [RL6]

    // Interrupt events: a flag rising; set beats a same-cycle clear
    wire [2:0] ev = flags & ~flag_q_ff;
    wire [2:0] clr = wr_ist ? wb_req.dat[2:0] : 3'h0;
    wire [2:0] nxt_int_status = (int_status_ff & ~clr) | ev;

    // Read mux
    wire [31:0] state_word = {26'h0, strap_ff, clk_on, flags};
    wire [31:0] nxt_rdat = hit_ctrl ? {28'h0, ctrl_ff} :
                           hit_thresh ? {16'h0, thresh_ff} :
                           hit_min ? {16'h0, min_pulse_ff} :
                           hit_state ? state_word :
                           hit_ist ? {29'h0, int_status_ff} :
                           hit_imask ? {29'h0, int_mask_ff} : 32'h0;

    // Straps caught once, right after reset release
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            strap_ff <= 2'h0;
            strap_taken_ff <= 1'b0;
        end
        else if (!strap_taken_ff)
        begin
            strap_ff <= clock_out_select_straps;
            strap_taken_ff <= 1'b1;
        end
    end

    // Reference sampled; divided clocks toggle on its rising edges
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ref_q_ff <= 1'b0;
            div2_ff <= 1'b0;
            div4_ff <= 2'h0;
            pin_ff <= 1'b0;
        end
        else
        begin
            ref_q_ff <= reference_clock_out;
            div2_ff <= div2_ff ^ ref_rise;
            div4_ff <= div4_ff + {1'b0, ref_rise};
            pin_ff <= nxt_pin;
        end
    end

    // Flag history; a rise is seen in the first cycle the flag is high, while this copy is still low
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            flag_q_ff <= 3'h0;
        else
            flag_q_ff <= flags;
    end

    // Wishbone slave with one wait state; unmapped reads give zero
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0;
        end
        else
        begin
            ack_ff <= req && !ack_ff;
            rdat_ff <= nxt_rdat;
        end
    end

    // ****************************************
    // Software registers, byte lanes honoured
    // ****************************************

    // Control: strap override, clock code and clock disable
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ctrl_ff <= orc_pkg::CTRL_RESET;
        else if (wr_ctrl)
            ctrl_ff <= wb_req.dat[3:0];
    end

    // Threshold; only the low SAMPLE_W bits reach the detectors
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            thresh_ff <= orc_pkg::THRESH_RESET;
        else
        begin
            if (wr_thresh_lo)
                thresh_ff[7:0] <= wb_req.dat[7:0];
            if (wr_thresh_hi)
                thresh_ff[15:8] <= wb_req.dat[15:8];
        end
    end

    // Minimum pulse; a new value takes effect at the next flag rise
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            min_pulse_ff <= orc_pkg::MIN_PULSE_RESET;
        else
        begin
            if (wr_min_lo)
                min_pulse_ff[7:0] <= wb_req.dat[7:0];
            if (wr_min_hi)
                min_pulse_ff[15:8] <= wb_req.dat[15:8];
        end
    end

    // Interrupt mask
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            int_mask_ff <= orc_pkg::INT_MASK_RESET;
        else if (wr_imask)
            int_mask_ff <= wb_req.dat[2:0];
    end

    // Interrupt status; an event beats a clear in the same cycle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            int_status_ff <= 3'h0;
        else
            int_status_ff <= nxt_int_status;
    end

    // Outputs
    assign wb_rsp.ack = ack_ff;
    assign wb_rsp.dat = rdat_ff;
    assign overrange_flag_a = flags[0];
    assign overrange_flag_b = flags[1];
    assign overrange_c_clock_pin = pin_ff;
    assign irq = |(int_status_ff & int_mask_ff);
endmodule

/* File: bench/orc_top_properties.sv */
/* Port assertions for orc_top.
   Assumes full-lane writes and straps that move only in reset. */
module orc_top_properties #(
    parameter int NUM_CHANNELS = 4,
    parameter int SAMPLE_W = 9
) (
    // Clock, reset, bus
    input wire logic clock,
    input wire logic rst,
    input wire orc_pkg::orc_wb_req_t wb_req,
    input wire orc_pkg::orc_wb_rsp_t wb_rsp,
    // Pins
    input wire logic [SAMPLE_W-1:0] sample_a,
    input wire logic [SAMPLE_W-1:0] sample_b,
    input wire logic [SAMPLE_W-1:0] sample_c,
    input wire logic [1:0] clock_out_select_straps,
    input wire logic synth_enable,
    input wire logic power_down_input,
    input wire logic reference_clock_out,
    input wire logic overrange_flag_a,
    input wire logic overrange_flag_b,
    input wire logic overrange_c_clock_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SAMPLE_W-1:0] thr_ff;
    logic [15:0] minp_ff;
    logic [15:0] held_ff;
    logic [3:0] ctrl_ff;
    // Shadow decode; a zero minimum acts as one cycle
    wire logic wr = wb_req.cyc && wb_req.stb && wb_req.we && wb_rsp.ack;
    wire logic [1:0] code = ctrl_ff[0] ? ctrl_ff[2:1] : clock_out_select_straps;
    wire logic act = code != 2'h0 && synth_enable && !power_down_input && !ctrl_ff[3];
    wire logic over_a = sample_a > thr_ff;
    wire logic [15:0] need = minp_ff == 16'h0 ? 16'h1 : minp_ff;
    // Writes land at the edge that samples ack, as in the design
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            thr_ff <= '0;
            minp_ff <= 16'h1;
            held_ff <= 16'h0;
            ctrl_ff <= 4'h0;
        end
        else
        begin
            held_ff <= overrange_flag_a ? held_ff + 16'h1 : 16'h0;
            if (wr && wb_req.adr == orc_pkg::ADDR_THRESH) thr_ff <= wb_req.dat[SAMPLE_W-1:0];
            if (wr && wb_req.adr == orc_pkg::ADDR_MIN_PULSE) minp_ff <= wb_req.dat[15:0];
            if (wr && wb_req.adr == orc_pkg::ADDR_CTRL) ctrl_ff <= wb_req.dat[3:0];
        end
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    AST_FLAG_A: assert property (over_a |=> overrange_flag_a) else $error("flag a");
    AST_FLAG_B: assert property (NUM_CHANNELS > 1 && sample_b > thr_ff |=> overrange_flag_b)
        else $error("flag b");
    AST_FLAG_C: assert property (NUM_CHANNELS > 3 && sample_c > thr_ff && !act ##1 !act
        |=> overrange_c_clock_pin) else $error("flag c");
    AST_MIN: assert property ($fell(overrange_flag_a) |-> held_ff >= need) else $error("short");
    AST_REL: assert property ($fell(overrange_flag_a) |-> !$past(over_a)) else $error("early");
    AST_COPY: assert property ((act && code == 2'h1)[*3]
        |-> overrange_c_clock_pin == $past(reference_clock_out, 2)) else $error("copy");
    AST_ACK: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack) else $error("ack");
    AST_ACK_LOW: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack long");
    COV_RISE: cover property ($rose(overrange_flag_a));
    COV_DIV4: cover property (act && code == 2'h3);
    COV_WIDE: cover property ($fell(overrange_flag_a) && need == 16'h8);
endmodule
bind orc_top orc_top_properties #(.NUM_CHANNELS(NUM_CHANNELS), .SAMPLE_W(SAMPLE_W)) orc_top_properties_inst (.*);

/* File: bench/orc_fpga_model.sv */
/* Far-side logic: sources the reference and counts pin C rises.
   Assumes the system clock; reference runs at a sixth of it. */
module orc_fpga_model (
    // Clock and watched pin
    input wire logic clock,
    input wire logic pin_c,
    input wire logic clr,
    // Reference and counts
    output logic ref_clk,
    output int ref_rises,
    output int pin_rises
);
    timeunit 1ns;
    timeprecision 1ps;
    int ph = 0;
    logic last_ff = 1'b0;
    logic ref_ff = 1'b0;
    assign ref_clk = ref_ff;
    // Slow reference so the sampled copy never misses a level
    always @(posedge clock)
    begin
        ph <= ph == 2 ? 0 : ph + 1;
        last_ff <= pin_c;
        if (ph == 2) ref_ff <= !ref_ff;
        ref_rises <= clr ? 0 : ref_rises + int'(ph == 2 && !ref_ff);
        pin_rises <= clr ? 0 : pin_rises + int'(pin_c && !last_ff);
    end
endmodule

/* File: bench/orc_top_tb.sv */
/* Bench for orc_top with a cycle model of flags, pin C and events.
   Assumes the partner sources the reference clock. */
module orc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic synth = 1'b1;
    logic pd = 1'b0;
    logic clr = 1'b0;
    logic [1:0] straps = 2'h0;
    logic [8:0] smp[3] = '{9'h0, 9'h0, 9'h0};
    orc_pkg::orc_wb_req_t req = '0;
    orc_pkg::orc_wb_rsp_t rsp;
    logic refc, fa, fb, pin, irq;
    logic [31:0] q;
    logic [3:0] lanes = 4'hf;
    int bad_count = 0, num_checks = 0, ref_n, pin_n, pin_ok = 1, m_pin = 0, m_ev = 0, m_thr = 0, m_minp = 1;
    int m_f[3] = '{0, 0, 0}, m_r[3] = '{0, 0, 0}, wd[4] = '{0, 1, 3, 8};
    int modes[6] = '{3, 5, 7, 11, 3, 3}, divs[6] = '{1, 2, 4, 99, 99, 99};
    always #5 clock = ~clock;
    orc_top #(.NUM_CHANNELS(4), .SAMPLE_W(9)) orc_top_inst (.clock(clock), .rst(rst), .wb_req(req),
        .wb_rsp(rsp), .sample_a(smp[0]), .sample_b(smp[1]), .sample_c(smp[2]), .clock_out_select_straps(straps),
        .synth_enable(synth), .power_down_input(pd), .reference_clock_out(refc), .overrange_flag_a(fa),
        .overrange_flag_b(fb), .overrange_c_clock_pin(pin), .irq(irq));
    orc_fpga_model orc_fpga_model_inst (.clock(clock), .pin_c(pin), .clr(clr), .ref_clk(refc),
        .ref_rises(ref_n), .pin_rises(pin_n));
    task automatic fail(input string m);
        bad_count++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic chk_bit(input logic g, input int e);
        num_checks++;
        if (g !== e[0]) fail("flag");
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) fail("read data");
    endtask
    task automatic chk_cnt(input int g, input int e);
        num_checks++;
        if (g > e + 1 || g < e - 1) fail("edge count");
    endtask
    // One classic cycle; holds the request until ack, the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b1, w, a, lanes, d};
        @(posedge clock);
        while (rsp.ack !== 1'b1)
            @(posedge clock);
        q = rsp.dat;
        if (w && a == orc_pkg::ADDR_THRESH) m_thr <= d;
        if (w && a == orc_pkg::ADDR_MIN_PULSE) m_minp <= d;
        req <= '0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk_word(q, e);
    endtask
    task automatic count_win(input int div);
        repeat (4) @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        repeat (120) @(posedge clock);
        chk_cnt(pin_n, ref_n / div);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Flag model: rise loads the width, fall needs quiet input and width spent
    always @(posedge clock)
    begin
        m_pin = m_f[2];
        for (int i = 0; i < 3; i++)
        begin
            if (rst) m_f[i] = 0;
            else if (!m_f[i] && smp[i] > m_thr)
            begin
                m_f[i] = 1;
                m_r[i] = m_minp == 0 ? 1 : m_minp;
                m_ev = m_ev | (1 << i);
            end
            else if (m_r[i] > 0) m_r[i]--;
            if (m_f[i] && m_r[i] == 0 && smp[i] <= m_thr) m_f[i] = 0;
        end
    end
    // Outputs compared mid-cycle, well clear of the launching edge
    always @(negedge clock)
    begin
        if (!rst) chk_bit(fa, m_f[0]);
        if (!rst) chk_bit(fb, m_f[1]);
        if (!rst && pin_ok) chk_bit(pin, m_pin);
    end
    initial
    begin
        void'($urandom(32'hd95a));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(orc_pkg::ADDR_MIN_PULSE, 32'h1);
        bus(1'b1, 8'h18, 32'h5);
        rd(8'h18, 32'h0);
        bus(1'b1, orc_pkg::ADDR_THRESH, 32'h100);
        rd(orc_pkg::ADDR_THRESH, 32'h100);
        foreach (wd[k])
        begin
            bus(1'b1, orc_pkg::ADDR_MIN_PULSE, wd[k]);
            repeat (150)
            begin
                @(posedge clock);
                foreach (smp[i]) smp[i] <= 9'h0f8 + 9'($urandom_range(15, 0));
            end
            smp <= '{9'h0, 9'h0, 9'h0};
            repeat (12) @(posedge clock);
        end
        rd(orc_pkg::ADDR_INT_STATUS, m_ev);
        chk_bit(irq, 0);
        bus(1'b1, orc_pkg::ADDR_INT_MASK, 32'h1);
        chk_bit(irq, m_ev & 1);
        // Lane 0 off: the mask must keep its value
        lanes = 4'he;
        bus(1'b1, orc_pkg::ADDR_INT_MASK, 32'h7);
        lanes = 4'hf;
        rd(orc_pkg::ADDR_INT_MASK, 32'h1);
        bus(1'b1, orc_pkg::ADDR_INT_STATUS, 32'h1);
        rd(orc_pkg::ADDR_INT_STATUS, m_ev & 6);
        chk_bit(irq, 0);
        pin_ok = 0;
        foreach (modes[k])
        begin
            bus(1'b1, orc_pkg::ADDR_CTRL, modes[k]);
            synth <= k != 4;
            pd <= k == 5;
            count_win(divs[k]);
        end
        straps <= 2'h3;
        pd <= 1'b0;
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        count_win(4);
        rd(orc_pkg::ADDR_STATE, 32'h38);
        stop_test;
    end
    // Run is near 1600 cycles; far past that is a hang
    initial
    begin
        #200000;
        fail("watchdog");
        stop_test;
    end
endmodule
